//--- hw/axil_mgmt_bridge.sv
// axi4-lite slave that drives the core's chip-select management port
// Overview of operation
// - each axi read or write becomes one management port access
// - read-not-write only meaningful while select is high at a clock edge
// - write request: select high with read-not-write low at rising edge
// - read request: select high with read-not-write high at rising edge
// - core's 32-bit read word is returned as axi read data
// - core ends a read with its own read acknowledge
// - core ends a write with its own write acknowledge
// - error with an acknowledge maps to an axi slave error response
`timescale 1ns/1ns
`include "axil_mgmt_bridge_defines.svh"
module axi_lite_to_core_mgmt_bridge (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output axil_mgmt_bridge_pkg::mgmt_req_t mgmtReq,
    input wire axil_mgmt_bridge_pkg::mgmt_rsp_t mgmtRsp
);
    import axil_mgmt_bridge_pkg::*;

    typedef enum logic [2:0] {IDLE, WRITE_BUSY, READ_BUSY, WRITE_RESP, READ_RESP} state_t;

    state_t state;
    state_t next_state;
    mgmt_req_t req;
    mgmt_req_t next_req;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic [1:0] rresp;
    logic [1:0] next_rresp;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic readTurn;
    logic next_readTurn;
    logic idle;
    logic writeBusy;
    logic readBusy;
    logic writeResp;
    logic readResp;
    logic doWrite;
    logic doRead;
    logic writeTaken;
    logic readTaken;
    logic writeDone;
    logic readDone;
    logic writeErr;
    logic readErr;
    logic bTaken;
    logic rTaken;

    // state decode shared by the handshakes and the next-value logic
    assign idle = state == IDLE;
    assign writeBusy = state == WRITE_BUSY;
    assign readBusy = state == READ_BUSY;
    assign writeResp = state == WRITE_RESP;
    assign readResp = state == READ_RESP;

    // address and data taken together; a write needs both channels present
    assign doWrite = s_axi_awvalid && s_axi_wvalid && !(s_axi_arvalid && readTurn);
    assign doRead = s_axi_arvalid && !doWrite;

    // readies drop while the enable is low, so a frozen edge never takes a request
    assign writeTaken = clkEn && idle && doWrite;
    assign readTaken = clkEn && idle && doRead;
    assign writeDone = writeBusy && mgmtRsp.writeAck;
    assign readDone = readBusy && mgmtRsp.readAck;
    // error counts only beside its own acknowledge
    assign writeErr = writeDone && mgmtRsp.accessError;
    assign readErr = readDone && mgmtRsp.accessError;
    assign bTaken = writeResp && s_axi_bready;
    assign rTaken = readResp && s_axi_rready;

    assign s_axi_awready = writeTaken;
    assign s_axi_wready = writeTaken;
    assign s_axi_arready = readTaken;
    assign s_axi_bvalid = writeResp;
    assign s_axi_rvalid = readResp;
    assign s_axi_bresp = bresp;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
    assign mgmtReq = req;

    // transfer sequencing
    always_comb begin
        next_state = state;
        case (state)
            IDLE: begin
                if (writeTaken) begin
                    next_state = WRITE_BUSY;
                end else if (readTaken) begin
                    next_state = READ_BUSY;
                end
            end
            WRITE_BUSY: begin
                // nothing new is taken until the master takes the write response, one at a time
                if (writeDone) begin
                    next_state = WRITE_RESP;
                end
            end
            READ_BUSY: begin
                if (readDone) begin
                    next_state = READ_RESP;
                end
            end
            WRITE_RESP: begin
                if (bTaken) begin
                    next_state = IDLE;
                end
            end
            READ_RESP: begin
                if (rTaken) begin
                    next_state = IDLE;
                end
            end
            default: begin
                next_state = IDLE;
            end
        endcase
    end

    // a hung core stalls the bridge; no timeout, as the core always answers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= IDLE;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    // read and write take turns when both are pending, so neither side starves
    always_comb begin
        next_readTurn = readTurn;
        if (writeTaken) begin
            next_readTurn = `TURN_TO_READ;
        end else if (readTaken) begin
            next_readTurn = `TURN_TO_WRITE;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readTurn <= `TURN_TO_WRITE;
        end else if (clkEn) begin
            readTurn <= next_readTurn;
        end
    end

    // request register; it stands unchanged from issue to acknowledge
    always_comb begin
        next_req = req;
        if (writeTaken) begin
            // write strobes are not carried: the port has no byte lanes
            next_req.select = `MGMT_SELECT_ON;
            next_req.readNotWrite = `MGMT_SEL_WRITE;
            next_req.regAddress = s_axi_awaddr;
            next_req.writeWord = s_axi_wdata;
        end else if (readTaken) begin
            next_req.select = `MGMT_SELECT_ON;
            next_req.readNotWrite = `MGMT_SEL_READ;
            next_req.regAddress = s_axi_araddr;
        end else if (writeDone || readDone || !(writeBusy || readBusy)) begin
            next_req.select = `MGMT_SELECT_OFF;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            req <= '0;
        end else if (clkEn) begin
            req <= next_req;
        end
    end

    // write status is caught on the acknowledge and stands until the master takes it
    always_comb begin
        next_bresp = bresp;
        if (writeDone) begin
            next_bresp = writeErr ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bresp <= `AXI_RESP_OKAY;
        end else if (clkEn) begin
            bresp <= next_bresp;
        end
    end

    // read answer is caught on the acknowledge, as the core's word may move afterwards
    always_comb begin
        next_rresp = rresp;
        next_rdata = rdata;
        if (readDone) begin
            next_rdata = mgmtRsp.readWord;
            next_rresp = readErr ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rresp <= `AXI_RESP_OKAY;
            rdata <= `WORD_ZERO;
        end else if (clkEn) begin
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end
endmodule

//--- pkg/axil_mgmt_bridge_defines.svh
// constants for the axi4-lite to management port bridge
`ifndef AXIL_MGMT_BRIDGE_DEFINES_SVH
`define AXIL_MGMT_BRIDGE_DEFINES_SVH
`define MGMT_SEL_WRITE 1'h0
`define MGMT_SEL_READ 1'h1
`define MGMT_SELECT_ON 1'h1
`define MGMT_SELECT_OFF 1'h0
`define TURN_TO_READ 1'h1
`define TURN_TO_WRITE 1'h0
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`define WORD_ZERO 32'h0000_0000
`define STRB_ALL 4'hF
`endif

//--- pkg/axil_mgmt_bridge_pkg.sv
// types shared by the management bridge and its bench
package axil_mgmt_bridge_pkg;
    typedef struct packed {
        logic select;
        logic readNotWrite;
        logic [31:0] regAddress;
        logic [31:0] writeWord;
    } mgmt_req_t;
    typedef struct packed {
        logic readAck;
        logic writeAck;
        logic accessError;
        logic [31:0] readWord;
    } mgmt_rsp_t;
endpackage

//--- verification/axil_mgmt_bridge_properties.sv
// port assertions for the management bridge
`timescale 1ns/1ns
module axil_mgmt_bridge_properties (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire axil_mgmt_bridge_pkg::mgmt_req_t mgmtReq,
    input wire axil_mgmt_bridge_pkg::mgmt_rsp_t mgmtRsp
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic sel = mgmtReq.select;
    wire logic rnw = mgmtReq.readNotWrite;
    wire logic rAck = mgmtRsp.readAck && sel && rnw;
    wire logic wAck = mgmtRsp.writeAck && sel && !rnw;
    property p_hold; sel && !rAck && !wAck |=> $stable(mgmtReq); endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_wr; s_axi_awready && s_axi_awvalid |=> sel && !rnw
        && mgmtReq.regAddress == $past(s_axi_awaddr)
        && mgmtReq.writeWord == $past(s_axi_wdata); endproperty
    a_wr: assert property (p_wr) else $error("no write request");
    property p_rd; s_axi_arready && s_axi_arvalid |=> sel && rnw
        && mgmtReq.regAddress == $past(s_axi_araddr); endproperty
    a_rd: assert property (p_rd) else $error("no read request");
    property p_one; sel |-> !s_axi_awready && !s_axi_arready; endproperty
    a_one: assert property (p_one) else $error("second request");
    // an acknowledge only counts on an enabled edge; a frozen edge moves nothing
    property p_rack; clkEn && rAck |=> s_axi_rvalid && !sel
        && s_axi_rdata == $past(mgmtRsp.readWord); endproperty
    a_rack: assert property (p_rack) else $error("read not ended");
    property p_wack; clkEn && wAck |=> s_axi_bvalid && !sel
        && s_axi_bresp == {$past(mgmtRsp.accessError), 1'h0}; endproperty
    a_wack: assert property (p_wack) else $error("write not ended");
    property p_err; clkEn && rAck |=>
        s_axi_rresp == {$past(mgmtRsp.accessError), 1'h0}; endproperty
    a_err: assert property (p_err) else $error("bad read status");
    property p_bv; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bv: assert property (p_bv) else $error("write status dropped");
    cover property (wAck);
    cover property (rAck);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (!clkEn && sel);
endmodule
bind axi_lite_to_core_mgmt_bridge axil_mgmt_bridge_properties chk (.*);

//--- verification/mgmt_core_model.sv
// core behind the management port, acks after a random wait
`timescale 1ns/1ns
module mgmt_core_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [1:0] lag,
    input wire axil_mgmt_bridge_pkg::mgmt_req_t mgmtReq,
    output axil_mgmt_bridge_pkg::mgmt_rsp_t mgmtRsp
);
    logic [1:0] waitCnt;
    // no answer in the cycle after an ack, the bridge has not dropped select yet
    wire logic go = mgmtReq.select && !mgmtRsp.readAck && !mgmtRsp.writeAck;
    wire logic hit = go && waitCnt >= lag;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mgmtRsp <= '0;
            waitCnt <= 2'h0;
        end else if (clkEn) begin
            // the core shares the enabled clock, so an ack stands until the bridge's next live edge
            waitCnt <= go ? waitCnt + 2'h1 : 2'h0;
            mgmtRsp.readAck <= hit && mgmtReq.readNotWrite;
            mgmtRsp.writeAck <= hit && !mgmtReq.readNotWrite;
            mgmtRsp.accessError <= hit && mgmtReq.regAddress[31];
            // idle data toggles so a stale word is never mistaken for an answer
            mgmtRsp.readWord <= hit ? ~mgmtReq.regAddress : ~mgmtRsp.readWord;
        end
    end
endmodule

//--- verification/tb_axi_lite_to_core_mgmt_bridge.sv
// self-checking bench for the management bridge
`timescale 1ns/1ns
`include "axil_mgmt_bridge_defines.svh"
`define CHK(n, e, s) begin checksDone++; if ((e) !== (s)) begin failCount++; \
    $display("unexpected %s: expected %h seen %h", n, e, s); end end
module tb_axi_lite_to_core_mgmt_bridge;
    import axil_mgmt_bridge_pkg::*;
    logic core_clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 0, s_axi_rready = 0, s_axi_awready, s_axi_arready, s_axi_bvalid;
    logic s_axi_rvalid, s_axi_wready, clkEn = 1'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, lag = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [31:0] seed = 32'h0001_2980, rnd;
    logic [33:0] wq[$], rq[$], e;
    mgmt_req_t mgmtReq;
    mgmt_rsp_t mgmtRsp;
    int failCount = 0, checksDone = 0, cyc = 0;
    axi_lite_to_core_mgmt_bridge dut (.*, .s_axi_wstrb(`STRB_ALL));
    mgmt_core_model far (.*);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic completeRun();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = {a, d, 2'h3};
        wq.push_back({a[31] ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY, `WORD_ZERO});
        do @(posedge core_clk); while (s_axi_awready !== 1'h1);
        `CHK("write ready", 1'h1, s_axi_wready)
        #1 {s_axi_awvalid, s_axi_wvalid} = 2'h0;
    endtask
    task automatic rd(input logic [31:0] a);
        {s_axi_araddr, s_axi_arvalid} = {a, 1'h1};
        rq.push_back({a[31] ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY, ~a});
        do @(posedge core_clk); while (s_axi_arready !== 1'h1);
        #1 s_axi_arvalid = 1'h0;
    endtask
    initial forever #50 core_clk = ~core_clk;
    // the far side stalls at random while the core answers late or at once
    always @(posedge core_clk) begin
        #1 rnd = xs();
        {s_axi_bready, s_axi_rready, lag} = rnd[3:0];
        // the enable drops about one edge in eight, freezing bridge and core together
        clkEn = |rnd[6:4];
    end
    // a handshake counts only on an enabled edge; an answer with no note is a mismatch
    always @(posedge core_clk) begin
        cyc++;
        // ceiling several times what the forty rounds should need
        if (cyc == 4000) begin
            failCount++;
            completeRun();
        end
        if (clkEn && s_axi_bvalid && s_axi_bready) begin
            e = wq.size() > 0 ? wq.pop_front() : 'x;
            `CHK("write status", e, {s_axi_bresp, `WORD_ZERO})
        end
        if (clkEn && s_axi_rvalid && s_axi_rready) begin
            e = rq.size() > 0 ? rq.pop_front() : 'x;
            `CHK("read answer", e, {s_axi_rresp, s_axi_rdata})
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #1 arst_n = 1;
        // reads and writes race each other so arbitration runs back to back
        for (int i = 0; i < 40; i++) begin
            fork
                wr(xs(), xs());
                rd(xs());
            join
            // let an edge pass so no valid is lowered and raised in one time step
            @(posedge core_clk);
            #1;
        end
        wait (wq.size() == 0 && rq.size() == 0);
        $display("mixed read and write test done");
        completeRun();
    end
endmodule
